// File: sfce_consts.vh
`ifndef SFCE_CONSTS_VH
`define SFCE_CONSTS_VH
`define SFCE_OP_WIDE_ENTER 8'hB7
`define SFCE_OP_WIDE_EXIT  8'hE9
`define SFCE_OP_WR_EN      8'h06
`define SFCE_OP_WR_DIS     8'h04
`define SFCE_OP_READ       8'h03
`define SFCE_OP_FAST       8'h0B
`define SFCE_OP_QFAST      8'hEB
`define SFCE_OP_ID_A       8'h9E
`define SFCE_OP_ID_B       8'h9F
`define SFCE_OP_PROG       8'h02
`define SFCE_OP_QPROG      8'h12
`define SFCE_OP_BULK       8'hC7
`define SFCE_ADDR_BITS     32
`define SFCE_DUMMY_FAST    6'h08
`define SFCE_DUMMY_QUAD    6'h0A
`define SFCE_PAGE_BYTES    256
`define SFCE_ERASED        8'hFF
`define SFCE_FIFO_DEPTH    8
`define SFCE_CLK_MHZ       125
`define SFCE_T_WB_US       600
`define SFCE_T_EB_S        240
`endif

// File: sfce_engine.v
`include "sfce_consts.vh"

module sfce_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         clk_en,
  input  wire         flush,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] slot [0:D-1];
  reg  [AW:0]  wp_reg;
  reg  [AW:0]  rp_reg;
  wire         full;
  wire         empty;

  assign full      = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty     = (wp_reg == rp_reg);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = slot[rp_reg[AW-1:0]];

  always @(posedge core_clk) begin
    if (rst) begin
      wp_reg <= {(AW+1){1'b0}};
      rp_reg <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (flush) begin
        wp_reg <= {(AW+1){1'b0}};
        rp_reg <= {(AW+1){1'b0}};
      end else begin
        if (in_valid && !full) begin
          slot[wp_reg[AW-1:0]] <= in_data;
          wp_reg <= wp_reg + 1'b1;
        end
        if (out_ready && !empty) begin
          rp_reg <= rp_reg + 1'b1;
        end
      end
    end
  end
endmodule // sfce_fifo

module sfce_engine #(
  parameter [39:0] PROG_CYC  = `SFCE_T_WB_US * `SFCE_CLK_MHZ,
  parameter [39:0] ERASE_CYC = `SFCE_T_EB_S * 40'd1000000 * `SFCE_CLK_MHZ,
  parameter [7:0]  PART_ID   = 8'h5A
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       clk_en,
  input  wire       serial_clock_pin,
  input  wire       select_low,
  input  wire [3:0] serial_line_in,
  output reg  [3:0] serial_line_out_reg,
  output reg  [3:0] serial_line_oe_reg,
  output reg        status_wel_reg,
  output reg        status_wip_reg,
  output reg        wide_address_reg
);
  // PART_ID default is arbitrary
  localparam MAW      = 12;
  localparam MEM_SIZE = 4096;
  localparam ST_OPC   = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_DUMMY = 3'd2;
  localparam ST_RDATA = 3'd3;
  localparam ST_ID    = 3'd4;
  localparam ST_PDATA = 3'd5;
  localparam ST_ERASE = 3'd6;
  localparam ST_IGN   = 3'd7;
  localparam B_IDLE   = 2'd0;
  localparam B_COMMIT = 2'd1;
  localparam B_WIPE   = 2'd2;
  localparam B_WAIT   = 2'd3;

  // Small array stands in for the die; the address wraps at its end
  reg  [7:0]     mem [0:MEM_SIZE-1];
  reg  [7:0]     pg_data [0:`SFCE_PAGE_BYTES-1];
  reg  [255:0]   pg_mask_reg;
  reg  [1:0]     sck_sync_reg;
  reg  [1:0]     cs_sync_reg;
  reg  [3:0]     d_s1_reg;
  reg  [3:0]     d_s2_reg;
  reg            sck_prev_reg;
  reg  [2:0]     state_reg;
  reg  [7:0]     op_reg;
  reg            quad_reg;
  reg  [31:0]    sh_reg;
  reg  [5:0]     cnt_reg;
  reg  [2:0]     ocnt_reg;
  reg  [7:0]     osh_reg;
  reg  [7:0]     pa_reg;
  reg  [MAW-9:0] page_reg;
  reg            have_data_reg;
  reg            fetch_on_reg;
  reg  [MAW-1:0] fa_reg;
  reg  [1:0]     bstate_reg;
  reg  [MAW-1:0] idx_reg;
  reg  [39:0]    timer_reg;
  wire           sck_rise;
  wire           sck_fall;
  wire           cs_high;
  wire           f_in_ready;
  wire           f_out_valid;
  wire [7:0]     f_out_data;
  wire           push;
  wire           pop;
  wire [31:0]    sh_next;
  wire [5:0]     nbits_last;
  wire [7:0]     opc_next;
  wire [7:0]     out_byte;

  function [31:0] shift_in;
    input [31:0] cur;
    input        four;
    input [3:0]  d;
    begin
      shift_in = four ? {cur[27:0], d} : {cur[30:0], d[0]};
    end
  endfunction

  assign sck_rise   = sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall   = ~sck_sync_reg[1] & sck_prev_reg;
  assign cs_high    = cs_sync_reg[1];
  assign opc_next   = {sh_reg[6:0], d_s2_reg[0]};
  assign sh_next    = shift_in(sh_reg, quad_reg, d_s2_reg);
  assign nbits_last = quad_reg ? 6'd7 : 6'd31;
  assign push       = fetch_on_reg & ~cs_high;
  assign pop        = sck_fall & ~cs_high & (state_reg == ST_RDATA) & (ocnt_reg == 3'd0) & f_out_valid;
  assign out_byte   = (ocnt_reg == 3'd0) ? f_out_data : osh_reg;

  sfce_fifo #(
    .W  (8),
    .D  (`SFCE_FIFO_DEPTH),
    .AW (3)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .flush     (cs_high),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (mem[fa_reg]),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  always @(posedge core_clk) begin
    if (rst) begin
      sck_sync_reg        <= 2'h0;
      cs_sync_reg         <= 2'h3;
      d_s1_reg            <= 4'h0;
      d_s2_reg            <= 4'h0;
      sck_prev_reg        <= 1'b0;
      state_reg           <= ST_OPC;
      op_reg              <= 8'h00;
      quad_reg            <= 1'b0;
      sh_reg              <= 32'h00000000;
      cnt_reg             <= 6'h00;
      ocnt_reg            <= 3'h0;
      osh_reg             <= 8'h00;
      pa_reg              <= 8'h00;
      page_reg            <= {(MAW-8){1'b0}};
      have_data_reg       <= 1'b0;
      fetch_on_reg        <= 1'b0;
      fa_reg              <= {MAW{1'b0}};
      bstate_reg          <= B_IDLE;
      idx_reg             <= {MAW{1'b0}};
      timer_reg           <= 40'h0000000000;
      pg_mask_reg         <= 256'h0;
      serial_line_out_reg <= 4'h0;
      serial_line_oe_reg  <= 4'h0;
      status_wel_reg      <= 1'b0;
      status_wip_reg      <= 1'b0;
      wide_address_reg    <= 1'b0;
    end else if (clk_en) begin
      // Pins pass two flops; clock and data share the same delay
      sck_sync_reg <= {sck_sync_reg[0], serial_clock_pin};
      cs_sync_reg  <= {cs_sync_reg[0], select_low};
      d_s1_reg     <= serial_line_in;
      d_s2_reg     <= d_s1_reg;
      sck_prev_reg <= sck_sync_reg[1];
      if (push && f_in_ready) begin
        fa_reg <= fa_reg + 1'b1;
      end

      case (bstate_reg)
        B_COMMIT: begin
          if (pg_mask_reg[idx_reg[7:0]]) begin
            mem[{page_reg, idx_reg[7:0]}] <= mem[{page_reg, idx_reg[7:0]}] & pg_data[idx_reg[7:0]];
          end
          pg_mask_reg[idx_reg[7:0]] <= 1'b0;
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg[7:0] == 8'hFF) begin
            bstate_reg <= B_WAIT;
            timer_reg  <= PROG_CYC;
          end
        end
        B_WIPE: begin
          mem[idx_reg] <= `SFCE_ERASED;
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == {MAW{1'b1}}) begin
            bstate_reg <= B_WAIT;
            timer_reg  <= ERASE_CYC;
          end
        end
        B_WAIT: begin
          timer_reg <= timer_reg - 1'b1;
          if (timer_reg <= 40'h0000000001) begin
            status_wel_reg <= 1'b0;
            status_wip_reg <= 1'b0;
            bstate_reg     <= B_IDLE;
          end
        end
        default: bstate_reg <= B_IDLE;
      endcase

      if (cs_high) begin
        state_reg          <= ST_OPC;
        cnt_reg            <= 6'h00;
        ocnt_reg           <= 3'h0;
        quad_reg           <= 1'b0;
        fetch_on_reg       <= 1'b0;
        have_data_reg      <= 1'b0;
        serial_line_oe_reg <= 4'h0;
        if (bstate_reg == B_IDLE && (state_reg == ST_ERASE || (state_reg == ST_PDATA && have_data_reg))) begin
          bstate_reg     <= (state_reg == ST_ERASE) ? B_WIPE : B_COMMIT;
          idx_reg        <= {MAW{1'b0}};
          status_wip_reg <= 1'b1;
        end
      end else if (sck_rise) begin
        case (state_reg)
          ST_OPC: begin
            sh_reg  <= {24'h000000, opc_next};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == 6'd7) begin
              op_reg  <= opc_next;
              cnt_reg <= 6'h00;
              state_reg <= ST_IGN;
              quad_reg  <= (opc_next == `SFCE_OP_QFAST) || (opc_next == `SFCE_OP_QPROG);
              case (opc_next)
                `SFCE_OP_WR_EN: status_wel_reg <= 1'b1;
                `SFCE_OP_WR_DIS: status_wel_reg <= 1'b0;
                `SFCE_OP_WIDE_ENTER: wide_address_reg <= 1'b1;
                `SFCE_OP_WIDE_EXIT: wide_address_reg <= 1'b0;
                `SFCE_OP_READ, `SFCE_OP_FAST, `SFCE_OP_QFAST: state_reg <= status_wip_reg ? ST_IGN : ST_ADDR;
                `SFCE_OP_ID_A, `SFCE_OP_ID_B: state_reg <= status_wip_reg ? ST_IGN : ST_ID;
                `SFCE_OP_PROG, `SFCE_OP_QPROG: state_reg <= (status_wel_reg && !status_wip_reg) ? ST_ADDR : ST_IGN;
                `SFCE_OP_BULK: state_reg <= (status_wel_reg && !status_wip_reg) ? ST_ERASE : ST_IGN;
                default: state_reg <= ST_IGN;
              endcase
            end
          end
          ST_ADDR: begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == nbits_last) begin
              cnt_reg  <= 6'h00;
              fa_reg   <= sh_next[MAW-1:0];
              pa_reg   <= sh_next[7:0];
              page_reg <= sh_next[MAW-1:8];
              if (op_reg == `SFCE_OP_PROG || op_reg == `SFCE_OP_QPROG) begin
                state_reg <= ST_PDATA;
              end else begin
                fetch_on_reg <= 1'b1;
                state_reg <= (op_reg == `SFCE_OP_READ) ? ST_RDATA : ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == (quad_reg ? `SFCE_DUMMY_QUAD : `SFCE_DUMMY_FAST) - 6'd1) begin
              state_reg <= ST_RDATA;
              cnt_reg   <= 6'h00;
            end
          end
          ST_PDATA: begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == (quad_reg ? 6'd1 : 6'd7)) begin
              cnt_reg <= 6'h00;
              pg_data[pa_reg] <= sh_next[7:0];
              pg_mask_reg[pa_reg] <= 1'b1;
              pa_reg <= pa_reg + 1'b1;
              have_data_reg <= 1'b1;
            end
          end
          default: state_reg <= state_reg;
        endcase
      end else if (sck_fall) begin
        if (state_reg == ST_RDATA) begin
          serial_line_out_reg <= quad_reg ? out_byte[7:4] : {2'b00, out_byte[7], 1'b0};
          serial_line_oe_reg  <= quad_reg ? 4'hF : 4'h2;
          osh_reg  <= quad_reg ? {out_byte[3:0], 4'h0} : {out_byte[6:0], 1'b0};
          ocnt_reg <= (ocnt_reg == 3'd0) ? (quad_reg ? 3'd1 : 3'd7) : ocnt_reg - 3'd1;
        end
        if (state_reg == ST_ID) begin
          serial_line_out_reg <= {2'b00, PART_ID[ocnt_reg], 1'b0};
          serial_line_oe_reg  <= 4'h2;
          ocnt_reg <= ocnt_reg + 1'b1;
        end
      end
    end
  end
endmodule // sfce_engine

// File: sfce_engine_properties.sv
module sfce_engine_properties #(
  parameter logic [39:0] PROG_CYC  = 40'h14,
  parameter logic [39:0] ERASE_CYC = 40'h14,
  parameter logic [7:0]  PART_ID   = 8'h00
) (
  input logic       core_clk,
  input logic       rst,
  input logic       serial_clock_pin,
  input logic       select_low,
  input logic [3:0] serial_line_out_reg,
  input logic [3:0] serial_line_oe_reg,
  input logic       status_wel_reg,
  input logic       status_wip_reg,
  input logic       wide_address_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Cycles since the raw link clock fell; saturates so idle time never wraps
  logic [7:0] fall_age;
  always_ff @(posedge core_clk) begin
    if (rst)
      fall_age <= 8'hFF;
    else if ($fell(serial_clock_pin))
      fall_age <= 8'h00;
    else if (fall_age != 8'hFF)
      fall_age <= fall_age + 8'h01;
  end
  sequence s_deselected;
    select_low [*8];
  endsequence
  sequence s_busy_run;
    status_wip_reg [*8];
  endsequence
  chk_reset_clear: assert property ($fell(rst) |->
    !status_wel_reg && !status_wip_reg && !wide_address_reg && serial_line_oe_reg == 4'h0)
    else $error("outputs not clear after reset");
  chk_oe_shape: assert property (serial_line_oe_reg inside {4'h0, 4'h2, 4'hF})
    else $error("illegal output enable pattern");
  chk_out_on_fall: assert property ($changed(serial_line_out_reg) &&
    serial_line_oe_reg != 4'h0 && $past(serial_line_oe_reg) != 4'h0 |-> fall_age < 8'h08)
    else $error("output data changed away from a falling edge");
  chk_desel_quiet: assert property (s_deselected |-> serial_line_oe_reg == 4'h0)
    else $error("lines driven while deselected");
  chk_busy_start: assert property ($rose(status_wip_reg) |-> select_low)
    else $error("busy began while selected");
  chk_busy_holds: assert property ($rose(status_wip_reg) |-> s_busy_run)
    else $error("busy cycle too short");
  chk_busy_needs_wel: assert property ($rose(status_wip_reg) |-> $past(status_wel_reg))
    else $error("busy cycle without write enable");
  chk_done_clears_wel: assert property ($fell(status_wip_reg) |-> !status_wel_reg)
    else $error("write enable still set after busy cycle");
  chk_busy_no_drive: assert property (status_wip_reg && $past(status_wip_reg, 8) |->
    serial_line_oe_reg == 4'h0)
    else $error("lines driven during busy cycle");
endmodule // sfce_engine_properties

bind sfce_engine sfce_engine_properties #(
  .PROG_CYC (PROG_CYC),
  .ERASE_CYC(ERASE_CYC),
  .PART_ID  (PART_ID)
) chk_u (
  .core_clk           (core_clk),
  .rst                (rst),
  .serial_clock_pin   (serial_clock_pin),
  .select_low         (select_low),
  .serial_line_out_reg(serial_line_out_reg),
  .serial_line_oe_reg (serial_line_oe_reg),
  .status_wel_reg     (status_wel_reg),
  .status_wip_reg     (status_wip_reg),
  .wide_address_reg   (wide_address_reg)
);

// File: sfce_engine_tb_top.sv
`include "sfce_consts.vh"
module sfce_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [7:0] TB_PART_ID = 8'hA6;
  logic       core_clk;
  logic       rst;
  logic       clk_en;
  wire        serial_clock_pin;
  wire        select_low;
  wire  [3:0] serial_line_in;
  wire  [3:0] serial_line_out_reg;
  wire  [3:0] serial_line_oe_reg;
  wire        status_wel_reg;
  wire        status_wip_reg;
  wire        wide_address_reg;
  int         failures;
  int         total_checks;
  logic [7:0] rd;
  logic [7:0] id_rev;
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // Short busy counts keep the run brief
  sfce_engine #(.PROG_CYC(40'h14), .ERASE_CYC(40'h14), .PART_ID(TB_PART_ID)) dut_u (
    .core_clk           (core_clk),
    .rst                (rst),
    .clk_en             (clk_en),
    .serial_clock_pin   (serial_clock_pin),
    .select_low         (select_low),
    .serial_line_in     (serial_line_in),
    .serial_line_out_reg(serial_line_out_reg),
    .serial_line_oe_reg (serial_line_oe_reg),
    .status_wel_reg     (status_wel_reg),
    .status_wip_reg     (status_wip_reg),
    .wide_address_reg   (wide_address_reg)
  );
  sfce_host_model host_u (
    .core_clk           (core_clk),
    .serial_line_out_reg(serial_line_out_reg),
    .serial_line_oe_reg (serial_line_oe_reg),
    .serial_clock_pin   (serial_clock_pin),
    .select_low         (select_low),
    .serial_line_in     (serial_line_in)
  );
  function automatic logic [7:0] flags();
    return {4'h0, |serial_line_oe_reg, status_wel_reg, status_wip_reg, wide_address_reg};
  endfunction
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wait_idle();
    for (int n = 0; status_wip_reg !== 1'h0; n++) begin
      if (n > 6000) begin
        failures++;
        give_verdict();
      end
      @(negedge core_clk);
    end
  endtask
  task t_flags();
    check(flags(), 8'h00);
    host_u.cmd(`SFCE_OP_WR_EN);
    check(flags(), 8'h04);
    host_u.cmd(`SFCE_OP_WIDE_ENTER);
    check(flags(), 8'h05);
    host_u.cmd(`SFCE_OP_WIDE_EXIT);
    check(flags(), 8'h04);
    // Frozen core must ignore a whole frame
    clk_en = 1'h0;
    host_u.cmd(`SFCE_OP_WR_DIS);
    check(flags(), 8'h04);
    clk_en = 1'h1;
    host_u.cmd(`SFCE_OP_WR_DIS);
    check(flags(), 8'h00);
  endtask
  task t_erase();
    host_u.cmd(`SFCE_OP_BULK);
    check(flags(), 8'h00);
    host_u.cmd(`SFCE_OP_WR_EN);
    host_u.cmd(`SFCE_OP_BULK);
    check(flags(), 8'h06);
    host_u.frame_open(`SFCE_OP_READ);
    host_u.addr(32'h0, 1'h0);
    host_u.get(rd, 1'h0);
    check(flags(), 8'h06);
    host_u.frame_close();
    wait_idle();
    check(flags(), 8'h00);
  endtask
  task prog(input logic [7:0] op, input logic [31:0] a, input logic q, input logic [23:0] d);
    host_u.cmd(`SFCE_OP_WR_EN);
    host_u.frame_open(op);
    host_u.addr(a, q);
    for (int i = 2; i >= 0; i--)
      host_u.put(d[8*i +: 8], q);
    host_u.frame_close();
    check(flags(), 8'h06);
    wait_idle();
    check(flags(), 8'h00);
  endtask
  task read_chk(input logic [7:0] op, input logic [31:0] a, input logic q, input int n, input logic [15:0] e);
    host_u.frame_open(op);
    host_u.addr(a, q);
    host_u.dummy(n);
    host_u.get(rd, q);
    check(rd, e[15:8]);
    host_u.get(rd, q);
    check(rd, e[7:0]);
    host_u.frame_close();
    check(flags(), 8'h00);
  endtask
  task t_reads();
    read_chk(`SFCE_OP_READ, 32'hFFF, 1'h0, 0, 16'hB25C);
    read_chk(`SFCE_OP_FAST, 32'hF00, 1'h0, 8, 16'hC3FF);
    read_chk(`SFCE_OP_QFAST, 32'h0, 1'h1, 10, 16'h5C6D);
    for (int b = 0; b < 8; b++)
      id_rev[7 - b] = TB_PART_ID[b];
    for (int k = 0; k < 2; k++) begin
      host_u.frame_open(k ? `SFCE_OP_ID_B : `SFCE_OP_ID_A);
      host_u.get(rd, 1'h0);
      check(rd, id_rev);
      host_u.frame_close();
    end
  endtask
  initial begin
    failures = 0;
    total_checks = 0;
    clk_en = 1'h1;
    rst = 1'h1;
    repeat (5) @(negedge core_clk);
    rst = 1'h0;
    host_u.wait_cyc(8);
    t_flags();
    t_erase();
    prog(`SFCE_OP_PROG, 32'hFFE, 1'h0, 24'hA1B2C3);
    prog(`SFCE_OP_QPROG, 32'h0, 1'h1, 24'h5C6D7E);
    t_reads();
    give_verdict();
  end
endmodule // sfce_engine_tb_top

// File: sfce_host_model.sv
module sfce_host_model (
  input  logic       core_clk,
  input  logic [3:0] serial_line_out_reg,
  input  logic [3:0] serial_line_oe_reg,
  output logic       serial_clock_pin,
  output logic       select_low,
  output logic [3:0] serial_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv_val;
  logic       drv_en;
  logic [3:0] rx;
  // Released lines show the inverse of the last value, never a stale copy
  assign serial_line_in = (serial_line_oe_reg & serial_line_out_reg) |
                          (~serial_line_oe_reg & (drv_en ? drv_val : ~drv_val));
  initial begin
    serial_clock_pin = 1'h0;
    select_low = 1'h1;
    drv_val = 4'h0;
    drv_en = 1'h0;
  end
  task wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // 160 ns period, sampled on rises
  task bit4(input logic [3:0] v, input logic en);
    if (en)
      drv_val = v;
    drv_en = en;
    wait_cyc(10);
    rx = serial_line_in;
    serial_clock_pin = 1'h1;
    wait_cyc(10);
    serial_clock_pin = 1'h0;
  endtask
  task put(input logic [7:0] b, input logic q);
    if (q) begin
      bit4(b[7:4], 1'h1);
      bit4(b[3:0], 1'h1);
    end else
      for (int i = 7; i >= 0; i--)
        bit4({3'h0, b[i]}, 1'h1);
  endtask
  task get(output logic [7:0] b, input logic q);
    if (q) begin
      bit4(4'h0, 1'h0);
      b[7:4] = rx;
      bit4(4'h0, 1'h0);
      b[3:0] = rx;
    end else
      for (int i = 7; i >= 0; i--) begin
        bit4(4'h0, 1'h0);
        b[i] = rx[1];
      end
  endtask
  task frame_open(input logic [7:0] op);
    select_low = 1'h0;
    wait_cyc(4);
    put(op, 1'h0);
  endtask
  task addr(input logic [31:0] a, input logic q);
    for (int i = 3; i >= 0; i--)
      put(a[8*i +: 8], q);
  endtask
  task dummy(input int n);
    repeat (n) bit4(4'h0, 1'h0);
  endtask
  // select held to the end, raised after last bit
  task frame_close();
    wait_cyc(4);
    drv_en = 1'h0;
    select_low = 1'h1;
    wait_cyc(8);
  endtask
  task cmd(input logic [7:0] op);
    frame_open(op);
    frame_close();
  endtask
endmodule // sfce_host_model
